//--- pbs_pkg.sv
// Shared widths, reset values and record types of the burst SRAM port
package pbs_pkg;
   localparam int ADDR_W     = 15;
   localparam int DATA_W     = 32;
   localparam int LANES      = 4;
   localparam int BURST_W    = 2;
   localparam int FIFO_DEPTH = 16;
   localparam int ENTRY_W    = ADDR_W + DATA_W + LANES;

   localparam logic [LANES-1:0] ALL_LANES = 4'hF;
   localparam logic [LANES-1:0] NO_LANES  = 4'h0;

   // Sampled pin set, one per clock edge
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              proc_addr_strobe_n;
      logic              controller_addr_strobe_n;
      logic              burst_advance_n;
      logic              chip_select_first_n;
      logic              chip_select_second_p;
      logic              chip_select_third_n;
      logic              global_write_n;
      logic              byte_write_enable_n;
      logic [LANES-1:0]  byte_lane_select_n;
      logic [DATA_W-1:0] din;
   } pbs_pins_t;

   // Reset image: all strobes and enables idle, device deselected
   localparam pbs_pins_t PINS_RESET = '{addr: 15'h0000, proc_addr_strobe_n: 1'b1,
      controller_addr_strobe_n: 1'b1, burst_advance_n: 1'b1, chip_select_first_n: 1'b1,
      chip_select_second_p: 1'b0, chip_select_third_n: 1'b1, global_write_n: 1'b1,
      byte_write_enable_n: 1'b1, byte_lane_select_n: 4'hF, din: 32'h0000_0000};

   // One queued write toward the array
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [LANES-1:0]  mask;
   } pbs_entry_t;

   localparam logic [BURST_W-1:0] BURST_RESET = 2'h0;
   localparam logic               SYNC_RESET  = 1'b0;
   localparam logic               OE_N_RESET  = 1'b1;
endpackage : pbs_pkg

//--- pbs_wr_if.sv
// Valid/ready channel carrying queued writes between the port and its FIFO
`timescale 1ns/1ps
interface pbs_wr_if #(parameter int WIDTH = pbs_pkg::ENTRY_W);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : pbs_wr_if

//--- pbs_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module pbs_fifo #(
   parameter int WIDTH = pbs_pkg::ENTRY_W,
   parameter int DEPTH = pbs_pkg::FIFO_DEPTH
) (
   input  wire logic i_clk,
   input  wire logic i_rst,
   pbs_wr_if.snk     push,
   pbs_wr_if.src     pop
);
   localparam int PW = $clog2(DEPTH);

   // Refuse depths that the pointer wrap cannot serve
   if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad_cfg
      $error("pbs_fifo: depth must be a power of two of at least two");
   end

   typedef struct packed {
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [PW:0]   count;
   } pbs_fifo_state_t;

   pbs_fifo_state_t  st;
   pbs_fifo_state_t  next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             do_push;
   logic             do_pop;

   // Full and empty come straight from the count, so both flags are exact
   assign push.ready = (st.count != (PW+1)'(DEPTH));
   assign pop.valid  = (st.count != '0);
   assign pop.data   = mem[st.rd_ptr];
   assign do_push    = push.valid && push.ready;
   assign do_pop     = pop.valid && pop.ready;

   // Pointer and count update
   always_comb begin
      next_st = st;
      if (do_push) next_st.wr_ptr = st.wr_ptr + 1'b1;
      if (do_pop)  next_st.rd_ptr = st.rd_ptr + 1'b1;
      if (do_push && !do_pop)      next_st.count = st.count + 1'b1;
      else if (do_pop && !do_push) next_st.count = st.count - 1'b1;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) st <= '0;
      else       st <= next_st;
   end

   // Storage has no reset; only the pointers and count define what is valid
   always_ff @(posedge i_clk) begin
      if (do_push) mem[st.wr_ptr] <= push.data;
   end
endmodule : pbs_fifo

//--- pbs_burst_ctr.sv
// Two-bit wraparound burst counter, linear or interleaved order
`timescale 1ns/1ps
module pbs_burst_ctr (
   input  wire logic                         i_clk,
   input  wire logic                         i_rst,
   input  wire logic                         i_load,
   input  wire logic [pbs_pkg::BURST_W-1:0]  i_start,
   input  wire logic                         i_step,
   input  wire logic                         i_linear,
   output logic      [pbs_pkg::BURST_W-1:0]  o_cur,
   output logic      [pbs_pkg::BURST_W-1:0]  o_next
);
   typedef struct packed {
      logic [pbs_pkg::BURST_W-1:0] start;
      logic [pbs_pkg::BURST_W-1:0] idx;
   } pbs_ctr_state_t;

   pbs_ctr_state_t              st;
   pbs_ctr_state_t              next_st;
   logic [pbs_pkg::BURST_W-1:0] idx_inc;

   assign idx_inc = st.idx + 1'b1;
   // Offset from the start word: sum wraps 11 to 00, xor walks 00..11
   assign o_cur  = i_linear ? st.start + st.idx : st.start ^ st.idx;
   assign o_next = i_linear ? st.start + idx_inc : st.start ^ idx_inc;

   // Load keeps the first burst word, step walks the other three
   always_comb begin
      next_st = st;
      if (i_load) begin
         next_st.start = i_start;
         next_st.idx   = pbs_pkg::BURST_RESET;
      end else if (i_step) begin
         next_st.idx = idx_inc;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) st <= '{start: pbs_pkg::BURST_RESET, idx: pbs_pkg::BURST_RESET};
      else       st <= next_st;
   end
endmodule : pbs_burst_ctr

//--- pbs_sram_port.sv
// Pipelined synchronous burst SRAM: pin registers, burst control, array
//
// Operation
// - All synchronous inputs are captured on the rising clock edge only.
// - Read data leaves through an output register clocked on the rising edge.
// - Driven data belongs to the address captured one edge earlier.
// - Selected only with first select low, second high, third low.
// - Output enable low lets the data lines drive.
// - Output enable high floats the data lines; they act as inputs.
// - First read cycle after deselect keeps the data lines floating.
// - Either strobe low captures the address and loads the burst counter.
// - Both strobes low: only the processor strobe is acted on.
// - Processor strobe ignored while first chip select is high.
// - Advance low during a burst steps the burst counter.
// - Two-bit wraparound counter holds start and supplies three more addresses.
// - Strap low gives linear order; high or floating gives interleaved.
// - Input data is captured into a data register on the rising edge.
// - Byte writes need byte-write enable low; each lane select enables its byte.
// - Global write low writes all four lanes regardless of byte controls.
// - Sleep high stops accesses while keeping stored contents.
// - Interleaved order xors the start with 00, 01, 10, 11.
// - Linear order adds one per step, wrapping 11 to 00.
// - Processor-strobe writes take two cycles; first-edge write controls ignored.
// - Any detected write cycle floats the data lines.
`timescale 1ns/1ps
module pbs_sram_port (
   input  wire logic                          i_clk,
   input  wire logic                          i_rst,
   input  wire logic [pbs_pkg::ADDR_W-1:0]    i_addr,
   input  wire logic                          i_proc_addr_strobe_n,
   input  wire logic                          i_controller_addr_strobe_n,
   input  wire logic                          i_burst_advance_n,
   input  wire logic                          i_chip_select_first_n,
   input  wire logic                          i_chip_select_second_p,
   input  wire logic                          i_chip_select_third_n,
   input  wire logic                          i_global_write_n,
   input  wire logic                          i_byte_write_enable_n,
   input  wire logic [pbs_pkg::LANES-1:0]     i_byte_lane_select_n,
   input  wire logic                          i_output_enable_n,
   input  wire logic                          i_sleep_request,
   input  wire logic                          i_burst_order_strap,
   input  wire logic [pbs_pkg::DATA_W-1:0]    i_dq,
   output logic      [pbs_pkg::DATA_W-1:0]    o_dq,
   output logic                               o_dq_oe_n,
   output logic                               o_write_ready,
   output logic                               o_sleeping
);
   localparam int DEPTH = 1 << pbs_pkg::ADDR_W;

   // Control state of the port outside the burst counter and FIFO
   typedef struct packed {
      pbs_pkg::pbs_pins_t            pins;
      logic                          oe_s1;
      logic                          oe_s2;
      logic                          zz_s1;
      logic                          zz_s2;
      logic                          mode_s1;
      logic                          mode_s2;
      logic                          active;
      logic                          processor_addr_strobe_n_pend;
      logic [pbs_pkg::ADDR_W-3:0]    addr_hi;
      logic [pbs_pkg::DATA_W-1:0]    dq_out;
      logic                          dq_oe_n;
      logic                          wr_ready;
   } pbs_state_t;

   pbs_state_t                        st;
   pbs_state_t                        next_st;
   logic [pbs_pkg::DATA_W-1:0]        mem [DEPTH];
   pbs_pkg::pbs_pins_t                pins_now;
   pbs_pkg::pbs_entry_t               head;
   pbs_pkg::pbs_entry_t               entry;
   logic                              sleep;
   logic                              sel;
   logic                              p_ok;
   logic                              c_ok;
   logic                              strobe;
   logic                              wr_req;
   logic                              wr_go;
   logic                              rd_go;
   logic                              advance;
   logic                              fwd_hit;
   logic [pbs_pkg::BURST_W-1:0]       ctr_cur;
   logic [pbs_pkg::BURST_W-1:0]       ctr_next;
   logic [pbs_pkg::BURST_W-1:0]       low2;
   logic [pbs_pkg::ADDR_W-1:0]        cur_addr;
   logic [pbs_pkg::LANES-1:0]         wr_mask;
   logic [pbs_pkg::DATA_W-1:0]        mem_word;
   logic [pbs_pkg::DATA_W-1:0]        rd_data;

   pbs_wr_if #(.WIDTH(pbs_pkg::ENTRY_W)) push_ch ();
   pbs_wr_if #(.WIDTH(pbs_pkg::ENTRY_W)) pop_ch ();

   // Pin image gathered for the input register
   assign pins_now = '{addr: i_addr, proc_addr_strobe_n: i_proc_addr_strobe_n,
      controller_addr_strobe_n: i_controller_addr_strobe_n,
      burst_advance_n: i_burst_advance_n, chip_select_first_n: i_chip_select_first_n,
      chip_select_second_p: i_chip_select_second_p,
      chip_select_third_n: i_chip_select_third_n, global_write_n: i_global_write_n,
      byte_write_enable_n: i_byte_write_enable_n,
      byte_lane_select_n: i_byte_lane_select_n, din: i_dq};

   // Decode of the registered pins; sleep suppresses every access
   assign sleep  = st.zz_s2;
   assign sel    = !st.pins.chip_select_first_n && st.pins.chip_select_second_p
                   && !st.pins.chip_select_third_n;
   assign p_ok   = !st.pins.proc_addr_strobe_n && !st.pins.chip_select_first_n;
   assign c_ok   = !st.pins.controller_addr_strobe_n;
   assign strobe = (p_ok || c_ok) && !sleep;
   assign wr_req = !st.pins.global_write_n || !st.pins.byte_write_enable_n;

   // Processor strobe wins and always opens with a read cycle
   assign wr_go = !sleep && ((strobe && sel && !p_ok && wr_req)
                  || (!strobe && st.active && wr_req));
   assign rd_go = !sleep && ((strobe && sel && (p_ok || !wr_req))
                  || (!strobe && st.active && !wr_req));

   // Advance is ignored on the strobe edge itself
   assign advance = !sleep && !strobe && st.active && !st.pins.burst_advance_n;

   pbs_burst_ctr u_ctr (
      .i_clk    (i_clk),
      .i_rst    (i_rst),
      .i_load   (strobe && sel),
      .i_start  (st.pins.addr[pbs_pkg::BURST_W-1:0]),
      .i_step   (advance),
      .i_linear (!st.mode_s2),
      .o_cur    (ctr_cur),
      .o_next   (ctr_next)
   );

   // Address of this cycle: fresh on a strobe, else burst word after any step
   assign low2     = strobe ? st.pins.addr[pbs_pkg::BURST_W-1:0]
                   : (advance ? ctr_next : ctr_cur);
   assign cur_addr = strobe ? st.pins.addr : {st.addr_hi, low2};

   // Global write forces every lane; byte writes need their enable
   always_comb begin
      if (!st.pins.global_write_n)
         wr_mask = pbs_pkg::ALL_LANES;
      else if (!st.pins.byte_write_enable_n)
         wr_mask = ~st.pins.byte_lane_select_n;
      else
         wr_mask = pbs_pkg::NO_LANES;
   end

   // Writes queue into the FIFO, captured data taken from the pin register
   assign entry          = '{addr: cur_addr, data: st.pins.din, mask: wr_mask};
   assign push_ch.valid  = wr_go;
   assign push_ch.data   = entry;
   assign head           = pop_ch.data;
   // Draining stops in sleep so the array is left untouched
   assign pop_ch.ready   = !sleep;

   pbs_fifo #(.WIDTH(pbs_pkg::ENTRY_W), .DEPTH(pbs_pkg::FIFO_DEPTH)) u_fifo (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .push  (push_ch.snk),
      .pop   (pop_ch.src)
   );

   // Only the FIFO head is forwarded; it is the sole write not yet in the
   // array whenever the drain is running, which is every awake cycle
   assign mem_word = mem[cur_addr];
   assign fwd_hit  = pop_ch.valid && (head.addr == cur_addr);
   always_comb begin
      rd_data = mem_word;
      for (int l = 0; l < pbs_pkg::LANES; l++) begin
         if (fwd_hit && head.mask[l])
            rd_data[l*8 +: 8] = head.data[l*8 +: 8];
      end
   end

   // Array update from the FIFO head, every masked byte lane on the same edge
   always_ff @(posedge i_clk) begin
      if (pop_ch.valid && pop_ch.ready) begin
         for (int l = 0; l < pbs_pkg::LANES; l++) begin
            if (head.mask[l])
               mem[head.addr][l*8 +: 8] <= head.data[l*8 +: 8];
         end
      end
   end

   // Next state: pin register, synchronisers, access sequencing and outputs
   always_comb begin
      next_st         = st;
      next_st.pins    = pins_now;
      next_st.oe_s1   = i_output_enable_n;
      next_st.oe_s2   = st.oe_s1;
      next_st.zz_s1   = i_sleep_request;
      next_st.zz_s2   = st.zz_s1;
      next_st.mode_s1 = i_burst_order_strap;
      next_st.mode_s2 = st.mode_s1;
      next_st.wr_ready = push_ch.ready;
      // Float unless a read below claims the lines
      next_st.dq_oe_n = 1'b1;
      if (sleep) begin
         next_st.active    = 1'b0;
         next_st.processor_addr_strobe_n_pend = 1'b0;
      end else if (strobe && !sel) begin
         // Deselect floats the lines at once
         next_st.active    = 1'b0;
         next_st.processor_addr_strobe_n_pend = 1'b0;
      end else if (strobe) begin
         next_st.active    = 1'b1;
         next_st.addr_hi   = st.pins.addr[pbs_pkg::ADDR_W-1:pbs_pkg::BURST_W];
         next_st.processor_addr_strobe_n_pend = p_ok;
         // Leaving deselect masks the first read cycle
         next_st.dq_oe_n   = !(rd_go && st.active && !st.oe_s2);
      end else if (st.active) begin
         next_st.processor_addr_strobe_n_pend = 1'b0;
         next_st.dq_oe_n   = !(rd_go && !st.oe_s2);
      end
      if (rd_go)
         next_st.dq_out = rd_data;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st <= '{pins: pbs_pkg::PINS_RESET, oe_s1: pbs_pkg::OE_N_RESET,
                 oe_s2: pbs_pkg::OE_N_RESET, zz_s1: pbs_pkg::SYNC_RESET,
                 zz_s2: pbs_pkg::SYNC_RESET, mode_s1: pbs_pkg::SYNC_RESET,
                 mode_s2: pbs_pkg::SYNC_RESET, active: 1'b0, processor_addr_strobe_n_pend: 1'b0,
                 addr_hi: '0, dq_out: '0, dq_oe_n: pbs_pkg::OE_N_RESET,
                 wr_ready: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // Every output is a flip-flop
   assign o_dq          = st.dq_out;
   assign o_dq_oe_n     = st.dq_oe_n;
   assign o_write_ready = st.wr_ready;
   assign o_sleeping    = st.zz_s2;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   a_sel_decode: assert property (strobe && !sel |=> !st.active && o_dq_oe_n)
      else $error("deselect did not clear the access");

   a_read_latency: assert property (
      rd_go && !fwd_hit && !(pop_ch.valid && pop_ch.ready)
      |=> o_dq == $past(mem_word))
      else $error("read data not from the address of the previous edge");

   a_first_mask: assert property (rd_go && strobe && !st.active |=> o_dq_oe_n)
      else $error("first read cycle after deselect drove the bus");

   a_write_float: assert property (wr_go |=> o_dq_oe_n)
      else $error("data lines driven during a write cycle");

   a_oe_float: assert property (st.oe_s2 |=> o_dq_oe_n)
      else $error("data lines driven with output enable high");

   a_oe_drive: assert property (
      rd_go && !strobe && !st.oe_s2 |=> !o_dq_oe_n)
      else $error("continuing read with output enable low did not drive");

   a_proc_first: assert property (
      p_ok && c_ok && sel && !sleep |=> st.processor_addr_strobe_n_pend)
      else $error("controller strobe acted while processor strobe was low");

   a_cs1_gate: assert property (
      !st.pins.proc_addr_strobe_n && st.pins.chip_select_first_n && !c_ok
      |-> !strobe)
      else $error("processor strobe taken with first chip select high");

   a_burst_load: assert property (
      strobe && sel ##1 !advance |-> ctr_cur == $past(st.pins.addr[1:0]))
      else $error("burst counter not loaded from the low address bits");

   a_global_all: assert property (wr_go && !st.pins.global_write_n
      |-> push_ch.data[pbs_pkg::LANES-1:0] == pbs_pkg::ALL_LANES)
      else $error("global write did not select all lanes");

   a_proc_wr_two: assert property (p_ok && sel && !sleep |-> !wr_go)
      else $error("write controls honoured on the processor strobe edge");

   a_sleep_hold: assert property (sleep |-> !push_ch.valid && !pop_ch.ready)
      else $error("access or drain while sleeping");
endmodule : pbs_sram_port

//--- pbs_bus_partner.sv
// Bus-side partner: drives the port pins and resolves the shared data lines
`timescale 1ns/1ps
module pbs_bus_partner (
   input  wire logic                       i_clk,
   input  wire logic [pbs_pkg::DATA_W-1:0] i_dev_dq,
   input  wire logic                       i_dev_oe_n,
   output pbs_pkg::pbs_pins_t              o_pins,
   output logic                            o_oe_n,
   output logic                            o_sleep,
   output logic                            o_strap
);
   pbs_pkg::pbs_pins_t pins;
   logic               drive;
   logic [31:0]        wdata;
   logic [31:0]        last;

   // Idle image; second and third selects stay active, first select gates access
   initial begin
      pins = pbs_pkg::PINS_RESET;
      pins.chip_select_second_p = 1'b1;
      pins.chip_select_third_n = 1'b0;
      drive = 1'b0;
      wdata = 32'h0000_0000;
      last = 32'h0000_0000;
      o_oe_n = 1'b1;
      o_sleep = 1'b0;
      o_strap = 1'b0;
   end

   // Released lines show a pattern that flips every cycle, never a stale word
   always_comb begin
      o_pins = pins;
      o_pins.din = !i_dev_oe_n ? i_dev_dq : (drive ? wdata : ~last);
   end
   always @(posedge i_clk) last <= o_pins.din;

   // Present one pin set just after an edge; it is sampled at the next edge
   task automatic put(input logic p_n, c_n, cs_n, adv_n, gw_n, bwe_n,
      input logic [3:0] ln_n, input logic [14:0] a, input logic [31:0] d, input logic drv);
      @(posedge i_clk);
      pins.proc_addr_strobe_n <= p_n;
      pins.controller_addr_strobe_n <= c_n;
      pins.chip_select_first_n <= cs_n;
      pins.burst_advance_n <= adv_n;
      pins.global_write_n <= gw_n;
      pins.byte_write_enable_n <= bwe_n;
      pins.byte_lane_select_n <= ln_n;
      pins.addr <= a;
      wdata <= d;
      drive <= drv;
   endtask : put

   // Second and third selects change with the pin set presented at this edge
   task automatic set_selects(input logic s2, s3);
      pins.chip_select_second_p <= s2;
      pins.chip_select_third_n <= s3;
   endtask : set_selects

   // Strap moves only while the bench holds reset
   task automatic set_strap(input logic s);
      o_strap <= s;
   endtask : set_strap

   // Async pins pass two sync flops and a register, so allow four edges
   task automatic set_async(input logic oe_n, input logic zz);
      @(posedge i_clk);
      o_oe_n <= oe_n;
      o_sleep <= zz;
      repeat (4) @(posedge i_clk);
   endtask : set_async
endmodule : pbs_bus_partner

//--- pbs_sram_port_tb.sv
// Self-checking bench of the burst SRAM port
`timescale 1ns/1ps
module pbs_sram_port_tb;
   logic               i_clk = 1'b0;
   logic               i_rst = 1'b1;
   pbs_pkg::pbs_pins_t pins;
   logic               oe_n, sleep, strap, dq_oe_n, wr_ready, sleeping;
   logic [31:0]        dq;
   logic [31:0]        ref_mem [0:15];
   int                 n_mismatch = 0;
   int                 check_count = 0;

   always #5 i_clk = ~i_clk;

   pbs_bus_partner partner_u (.i_clk(i_clk), .i_dev_dq(dq), .i_dev_oe_n(dq_oe_n),
      .o_pins(pins), .o_oe_n(oe_n), .o_sleep(sleep), .o_strap(strap));

   pbs_sram_port dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(pins.addr),
      .i_proc_addr_strobe_n(pins.proc_addr_strobe_n),
      .i_controller_addr_strobe_n(pins.controller_addr_strobe_n),
      .i_burst_advance_n(pins.burst_advance_n),
      .i_chip_select_first_n(pins.chip_select_first_n),
      .i_chip_select_second_p(pins.chip_select_second_p),
      .i_chip_select_third_n(pins.chip_select_third_n),
      .i_global_write_n(pins.global_write_n), .i_byte_write_enable_n(pins.byte_write_enable_n),
      .i_byte_lane_select_n(pins.byte_lane_select_n), .i_output_enable_n(oe_n),
      .i_sleep_request(sleep), .i_burst_order_strap(strap), .i_dq(pins.din),
      .o_dq(dq), .o_dq_oe_n(dq_oe_n), .o_write_ready(wr_ready), .o_sleeping(sleeping));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize();
      if (n_mismatch == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize

   // Strap only moves while reset is held, never during operation
   task automatic do_reset(input logic order);
      @(posedge i_clk);
      i_rst <= 1'b1;
      partner_u.set_strap(order);
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
   endtask : do_reset

   task automatic idle();
      partner_u.put(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, 15'h0, 32'h0, 1'b0);
   endtask : idle

   // Controller-strobe write: data travels with the strobe
   task automatic wr(input logic [14:0] a, input logic [31:0] d, input logic gw_n, bwe_n,
      input logic [3:0] ln_n);
      partner_u.put(1'b1, 1'b0, 1'b0, 1'b1, gw_n, bwe_n, ln_n, a, d, 1'b1);
   endtask : wr

   function automatic logic [31:0] merge(input logic [31:0] old, d, input logic [3:0] en);
      for (int i = 0; i < 4; i++) if (en[i]) old[8*i +: 8] = d[8*i +: 8];
      return old;
   endfunction : merge

   // Deselect, then a four-beat burst read; first beat must stay floated
   task automatic rd_burst(input logic [14:0] a, input logic lin, input logic oe_exp);
      logic [1:0] s;
      partner_u.put(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, a, 32'h0, 1'b0);
      partner_u.put(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, a, 32'h0, 1'b0);
      partner_u.put(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'hF, a, 32'h0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         partner_u.put(1'b1, 1'b1, 1'b0, i >= 2, 1'b1, 1'b1, 4'hF, a, 32'h0, 1'b0);
         #1;
         s = lin ? a[1:0] + i[1:0] : a[1:0] ^ i[1:0];
         check(dq, ref_mem[{a[3:2], s}]);
         check(dq_oe_n, (i == 0) | oe_exp);
      end
   endtask : rd_burst

   // Strobe during a driving burst: processor strobe under first select high is
   // ignored, while second or third select inactive deselects and floats the lines
   task automatic sel_chk(input logic p_n, s2, s3, input logic oe_exp);
      rd_burst(15'h0, 1'b0, 1'b0);
      partner_u.put(p_n, !p_n, !p_n, 1'b1, 1'b1, 1'b1, 4'hF, 15'h1, 32'h0, 1'b0);
      partner_u.set_selects(s2, s3);
      idle();
      partner_u.set_selects(1'b1, 1'b0);
      idle();
      #1;
      check(dq_oe_n, oe_exp);
   endtask : sel_chk

   // Cut a hang short well beyond the expected run time
   initial begin
      #100_000;
      n_mismatch++;
      summarize();
   end

   initial begin
      do_reset(1'b0);
      partner_u.set_async(1'b1, 1'b0);
      for (int i = 0; i < 16; i++) begin
         wr(i[14:0], 32'hC0DE_0000 + i, 1'b0, i[0], 4'hE);
         ref_mem[i] = 32'hC0DE_0000 + i;
      end
      wr(15'h5, 32'h1122_3344, 1'b1, 1'b0, 4'hA);
      ref_mem[5] = merge(ref_mem[5], 32'h1122_3344, 4'h5);
      wr(15'h6, 32'hDEAD_BEEF, 1'b1, 1'b1, 4'h0);
      // Both strobes: processor strobe wins, so first-edge write controls are ignored
      // Second edge writes lane 0 only, so a first-edge global write would show
      partner_u.put(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 4'hF, 15'h7, 32'hBAD0_BAD0, 1'b1);
      partner_u.put(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'hE, 15'h0, 32'h5A5A_5A5A, 1'b1);
      idle();
      ref_mem[7] = merge(ref_mem[7], 32'h5A5A_5A5A, 4'h1);
      #1;
      check(wr_ready, 1'b1);
      partner_u.set_async(1'b0, 1'b0);
      rd_burst(15'h5, 1'b1, 1'b0);
      do_reset(1'b1);
      partner_u.set_async(1'b0, 1'b0);
      rd_burst(15'h6, 1'b0, 1'b0);
      sel_chk(1'b0, 1'b1, 1'b0, 1'b0);
      sel_chk(1'b1, 1'b0, 1'b0, 1'b1);
      sel_chk(1'b1, 1'b1, 1'b1, 1'b1);
      partner_u.set_async(1'b1, 1'b0);
      rd_burst(15'h9, 1'b0, 1'b1);
      partner_u.set_async(1'b1, 1'b1);
      check(sleeping, 1'b1);
      wr(15'h3, 32'h0BAD_F00D, 1'b0, 1'b1, 4'hF);
      idle();
      partner_u.set_async(1'b0, 1'b0);
      check(sleeping, 1'b0);
      rd_burst(15'h3, 1'b0, 1'b0);
      summarize();
   end
endmodule : pbs_sram_port_tb
